// ===== design/sar_conversion_sequencer.sv
`timescale 1ns/1ps
module sar_conversion_sequencer #(
  parameter int unsigned STEP_DIV = sar_seq_pkg::STEP_DIV
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_convert_strobe,
  input  wire logic        i_chain_select_input,
  input  wire logic        i_serial_clk,
  input  wire logic        i_comp_positive,
  input  wire logic        i_over_range,
  input  wire logic        i_under_range,
  output logic             o_pos_array_ground_switch,
  output logic             o_neg_array_ground_switch,
  output logic             o_arrays_to_ground,
  output logic [15:0]      o_trial_code,
  output logic             o_powered_up,
  output logic             o_busy,
  output logic             o_done,
  output logic [15:0]      o_result,
  output logic             o_chain_mode,
  output logic             o_result_serial_out
);
  logic cnv_s;
  logic chn_s;
  logic sck_s;
  logic cnv_d_r;
  logic sck_d_r;

  // Pins from outside the clock domain pass two flip-flops first.
  sync2 u_sync_cnv (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_d       (i_convert_strobe),
    .o_q       (cnv_s)
  );

  sync2 u_sync_chn (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_d       (i_chain_select_input),
    .o_q       (chn_s)
  );

  sync2 u_sync_sck (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_d       (i_serial_clk),
    .o_q       (sck_s)
  );

  sar_seq_pkg::seq_state_t state_r;
  sar_seq_pkg::seq_state_t state_nxt;
  logic [15:0] code_r;
  logic [15:0] code_nxt;
  logic [15:0] mask_r;
  logic [15:0] mask_nxt;
  logic [7:0]  div_r;
  logic [15:0] shift_r;

  wire        cnv_rise    = cnv_s & ~cnv_d_r;
  wire        sck_fall    = sck_d_r & ~sck_s;
  wire        in_acq      = (state_r == sar_seq_pkg::ST_ACQ);
  wire        in_trial    = (state_r == sar_seq_pkg::ST_TRIAL);
  wire        take_strobe = cnv_rise & in_acq;
  wire        step_tick   = (div_r == 8'(STEP_DIV - 1));
  wire        last_bit    = mask_r[0];
  wire        sign_trial  = mask_r[15];
  // Two's complement trial: the sign bit carries inverted weight, so keep means negative side.
  wire        keep_bit    = sign_trial ? ~i_comp_positive : i_comp_positive;
  wire [15:0] trial_kept  = keep_bit ? code_r : (code_r & ~mask_r);
  wire [15:0] mask_down   = mask_r >> 1;
  wire [15:0] trial_next  = trial_kept | mask_down;
  // Saturation of out-of-span inputs.
  wire [15:0] final_code  = i_over_range  ? sar_seq_pkg::CODE_POS_MAX :
                            i_under_range ? sar_seq_pkg::CODE_NEG_MAX :
                            trial_next;

  always_comb begin
    state_nxt = state_r;
    code_nxt  = code_r;
    mask_nxt  = mask_r;
    case (state_r)
      sar_seq_pkg::ST_ACQ: begin
        if (take_strobe) begin
          state_nxt = sar_seq_pkg::ST_OPEN_SW;
        end
      end
      sar_seq_pkg::ST_OPEN_SW: begin
        state_nxt = sar_seq_pkg::ST_GROUND;
      end
      sar_seq_pkg::ST_GROUND: begin
        state_nxt = sar_seq_pkg::ST_TRIAL;
        mask_nxt  = sar_seq_pkg::TRIAL_FIRST;
        code_nxt  = sar_seq_pkg::TRIAL_FIRST;
      end
      sar_seq_pkg::ST_TRIAL: begin
        if (step_tick) begin
          code_nxt = trial_next;
          mask_nxt = mask_down;
          if (last_bit) begin
            state_nxt = sar_seq_pkg::ST_DONE;
          end
        end
      end
      sar_seq_pkg::ST_DONE: begin
        state_nxt = sar_seq_pkg::ST_ACQ;
      end
      default: begin
        state_nxt = sar_seq_pkg::ST_ACQ;
      end
    endcase
  end

  wire in_conv    = (state_nxt != sar_seq_pkg::ST_ACQ);
  wire ground_nxt = in_conv && (state_nxt != sar_seq_pkg::ST_OPEN_SW);
  wire finish     = in_trial && step_tick && last_bit;
  wire shift_en   = sck_fall && !o_busy;
  wire fill_bit   = o_chain_mode ? chn_s : 1'b0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_r <= sar_seq_pkg::ST_ACQ;
      code_r  <= sar_seq_pkg::CODE_RESET;
      mask_r  <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      code_r  <= code_nxt;
      mask_r  <= mask_nxt;
    end
  end

  // Delayed copies of the synchronised pins feed the edge detectors.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cnv_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      cnv_d_r <= cnv_s;
      sck_d_r <= sck_s;
    end
  end

  // Internal conversion clock divider, free of the serial clock.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || !in_trial || step_tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Ground switches stay closed in acquisition and open first on a conversion.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_pos_array_ground_switch <= 1'b1;
      o_neg_array_ground_switch <= 1'b1;
    end else begin
      o_pos_array_ground_switch <= ~in_conv;
      o_neg_array_ground_switch <= ~in_conv;
    end
  end

  // The arrays leave the inputs only once the switches are open.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_arrays_to_ground <= 1'b0;
    end else begin
      o_arrays_to_ground <= ground_nxt;
    end
  end

  // The core is powered, and reported busy, only while a conversion runs.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_powered_up <= 1'b0;
      o_busy       <= 1'b0;
    end else begin
      o_powered_up <= in_conv;
      o_busy       <= in_conv;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_trial_code <= sar_seq_pkg::CODE_RESET;
    end else begin
      o_trial_code <= code_nxt;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_done <= 1'b0;
    end else begin
      o_done <= finish;
    end
  end

  // The interface mode is taken only on a strobe accepted in acquisition.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_chain_mode <= 1'b0;
    end else if (take_strobe) begin
      o_chain_mode <= ~chn_s;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_result <= sar_seq_pkg::CODE_RESET;
    end else if (finish) begin
      o_result <= final_code;
    end
  end

  // The serial clock is ignored while busy, so it cannot disturb a conversion.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      shift_r             <= sar_seq_pkg::CODE_RESET;
      o_result_serial_out <= 1'b0;
    end else if (finish) begin
      shift_r             <= {final_code[14:0], 1'b0};
      o_result_serial_out <= final_code[15];
    end else if (shift_en) begin
      shift_r             <= {shift_r[14:0], fill_bit};
      o_result_serial_out <= shift_r[15];
    end
  end
endmodule : sar_conversion_sequencer

// ===== design/sar_seq_pkg.sv
// Contract
// - A rising edge of the convert strobe ends acquisition and starts a conversion on the held sample.
// - Conversion first opens both ground switches, then moves the arrays from the inputs to ground.
// - The result is resolved over 16 halving weights, most significant first, down to the smallest step.
// - After the last decision the block returns to acquisition, presents the code and pulses done.
// - Stepping is paced by an internal conversion clock, never by the serial clock.
// - The code is 16-bit two's complement of the differential input.
// - An input above the span saturates at the maximum positive code.
// - An input below the negative limit saturates at the most negative code.
// - Conversions up to 500 kSPS are supported and the core powers down between them.
// - The result belongs to the sample of the same strobe, with no pipeline delay.
// - The interface mode is latched at the strobe edge: chained when the select input is low.
// - When selected, the result is shifted out on the serial output on serial clock edges.
package sar_seq_pkg;
  localparam int unsigned RES_BITS      = 16;
  localparam int unsigned CLK_HZ        = 100000000;
  localparam int unsigned MAX_RATE_SPS  = 500000;
  localparam int unsigned CYCLE_CNT     = CLK_HZ / MAX_RATE_SPS;
  localparam int unsigned STEP_DIV      = 4;
  localparam logic [15:0] CODE_POS_MAX  = 16'h7fff;
  localparam logic [15:0] CODE_NEG_MAX  = 16'h8000;
  localparam logic [15:0] CODE_RESET    = 16'h0000;
  localparam logic [15:0] TRIAL_FIRST   = 16'h8000;
  typedef enum logic [2:0] {ST_ACQ, ST_OPEN_SW, ST_GROUND, ST_TRIAL, ST_DONE} seq_state_t;
endpackage : sar_seq_pkg

// ===== design/sync2.sv
`timescale 1ns/1ps
module sync2 (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      meta_r <= 1'b0;
      o_q    <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule : sync2

// ===== tb/cmp_model.sv
`timescale 1ns/1ps
module cmp_model (
  input  wire logic [15:0] i_trial,
  input  int               i_vin,
  output logic             o_pos,
  output logic             o_over,
  output logic             o_under
);
  // The sign trial compares the held sample to zero.
  assign o_pos   = (i_trial == 16'h8000) ? (i_vin >= 0) : (i_vin >= $signed(i_trial));
  assign o_over  = i_vin > 32767;
  assign o_under = i_vin < -32768;
endmodule : cmp_model

// ===== tb/sar_conversion_sequencer_chk.sv
`timescale 1ns/1ps
module sar_seq_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  input wire logic        o_pos_array_ground_switch,
  input wire logic        o_neg_array_ground_switch,
  input wire logic        o_arrays_to_ground,
  input wire logic [15:0] o_trial_code,
  input wire logic        o_powered_up,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [15:0] o_result,
  input wire logic        o_result_serial_out
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire sw_open = !o_pos_array_ground_switch && !o_neg_array_ground_switch;
  sequence s_open; sw_open && !o_arrays_to_ground; endsequence
  sequence s_ground; sw_open && o_arrays_to_ground; endsequence
  sequence s_msb_trial; sw_open && o_arrays_to_ground && o_trial_code == 16'h8000; endsequence
  AST_OPEN_FIRST: assert property ($rose(o_busy) |-> s_open ##1 s_ground ##1 s_msb_trial)
    else $error("switch order wrong");
  AST_GROUND_AFTER_OPEN: assert property ($rose(o_arrays_to_ground) |-> $past(sw_open))
    else $error("ground before open");
  AST_DECISIONS: assert property ($rose(o_busy) |-> ##[16:300] o_done)
    else $error("done too early or late");
  AST_DONE_PULSE: assert property (o_done |=> !o_done)
    else $error("done too long");
  AST_RETURN_ACQ: assert property (o_done |-> ##[0:1] (!sw_open && !o_arrays_to_ground))
    else $error("no return to acquisition");
  AST_POWER_DOWN: assert property (!o_busy && !$past(o_busy) |-> !o_powered_up)
    else $error("powered while idle");
  AST_MSB_OUT: assert property (o_done |-> o_result_serial_out == o_result[15])
    else $error("serial msb wrong");
  AST_RESULT_HOLD: assert property ($changed(o_result) |-> o_done)
    else $error("result moved without done");
endmodule : sar_seq_chk
bind sar_conversion_sequencer sar_seq_chk u_chk (.*);

// ===== tb/sar_conversion_sequencer_bench.sv
`timescale 1ns/1ps
module sar_conversion_sequencer_bench;
  logic        clk = 0, rstn = 0, convert_strobe = 0, sel = 1, sck = 0, pos, ovr, und, done, chain, result_serial_out;
  logic [15:0] trial, result;
  logic [31:0] seed = 32'h48;
  int          vin = 0, miscompares = 0, checks_done = 0;
  int          corner[8] = '{32767, 0, -1, -32768, 1, -32767, 40000, -40000};
  initial begin
    forever #5 clk = ~clk;
  end
  cmp_model PM (.i_trial(trial), .i_vin(vin), .o_pos(pos), .o_over(ovr), .o_under(und));
  sar_conversion_sequencer #(.STEP_DIV(1)) DUT (.i_sys_clk(clk), .i_rstn(rstn),
    .i_convert_strobe(convert_strobe), .i_chain_select_input(sel), .i_serial_clk(sck),
    .i_comp_positive(pos), .i_over_range(ovr), .i_under_range(und),
    .o_pos_array_ground_switch(), .o_neg_array_ground_switch(), .o_arrays_to_ground(),
    .o_trial_code(trial), .o_powered_up(), .o_busy(), .o_done(done), .o_result(result),
    .o_chain_mode(chain), .o_result_serial_out(result_serial_out));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [15:0] expect_code(input int v);
    return v > 32767 ? 16'h7fff : (v < -32768 ? 16'h8000 : v[15:0]);
  endfunction : expect_code
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp16
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic convert(input int v, input logic s);
    int n;
    int b;
    logic [15:0] exp_v;
    n = 0;
    vin = v;
    sel = s;
    @(negedge clk);
    convert_strobe = 1;
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      seed = xs(seed);
      // The serial clock toggles only while busy, so the readout starts from a quiet line.
      sck = seed[0] & (n < 12);
      convert_strobe = (n < 5 || n > 7);
      n++;
    end
    if (n == 300) begin
      miscompares++;
      summarize();
    end
    exp_v = expect_code(v);
    cmp16("result", exp_v, result);
    cmp16("chain mode", {15'h0, !s}, {15'h0, chain});
    for (b = 15; b >= 0; b--) begin
      cmp16("serial bit", {15'h0, exp_v[b]}, {15'h0, result_serial_out});
      sck = 1;
      repeat (3) @(negedge clk);
      sck = 0;
      repeat (3) @(negedge clk);
    end
    @(negedge clk);
    convert_strobe = 0;
    repeat (4) @(negedge clk);
  endtask : convert
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1;
    foreach (corner[i]) convert(corner[i], i[0]);
    repeat (20) begin
      seed = xs(seed);
      convert($signed(seed[16:0]), seed[20]);
    end
    summarize();
  end
endmodule : sar_conversion_sequencer_bench
